//--- verilog/system_serial_timer_control.sv
// Operation
// - The switch bit routes the primary chip-select-2 and write inputs to the host port at 0, the alternate ones at 1.
// - The multiprocessor enable bit turns serial multiprocessor communication on at 1 and off at 0.
// - The two-wire register enable bit makes that interface's registers usable at 1 and disables them at 0, its reset value.
// - The two-wire bit clock is the peripheral clock divided by a ratio chosen by the extend bit and three select bits.
// - The extra buffer select bit leaves the upper port A pins as plain I/O at 0 and gives them to bus drive at 1.
// - The standby bit makes a sleep instruction enter sleep at 0 and software standby at 1.
// - The two timer clock extension bits go to both 8-bit timers to widen their clock choice.
// - On the small flash part the two remap bits lay RAM over low ROM as the small table gives.
// - On the large flash part the two remap bits lay RAM over low ROM as the large table gives.
// - The sense register holds one bit per pin, 0 for level and 1 for edge sensing, all zero after reset.
// - The enable register holds one bit per pin and a pin's request is taken only while its bit is one.
`timescale 1ns/1ps
module system_serial_timer_control #(
   parameter bit LARGE_FLASH = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [sys_ctrl_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic host_chip_select_two_n,
   input wire logic host_io_write_n,
   input wire logic alt_host_chip_select_two_n,
   input wire logic alt_host_io_write_n,
   output logic slave_chip_select_two_n,
   output logic slave_io_write_n,
   output logic multiproc_comm_enable,
   output logic two_wire_register_enable,
   input wire logic [2:0] two_wire_div_sel,
   output logic [8:0] two_wire_ratio,
   output logic two_wire_bit_tick,
   output logic port_a_upper_pins_bus_drive,
   output logic [1:0] timer_clk_ext,
   input wire logic sleep_request,
   output logic enter_sleep,
   output logic enter_standby,
   output sys_ctrl_pkg::remap_t remap,
   input wire logic [sys_ctrl_pkg::PIN_COUNT-1:0] irq_pin_n,
   output logic [sys_ctrl_pkg::PIN_COUNT-1:0] irq_request,
   output logic irq
);
   import sys_ctrl_pkg::*;

   localparam int unsigned SYNC_W = PIN_COUNT + 4;

   serial_timer_t st_reg, st_next;
   logic [7:0] system_reg, system_next;
   logic [7:0] sense_reg, sense_next;
   logic [7:0] enable_reg, enable_next;
   logic [7:0] status_reg, status_next;
   logic [7:0] mask_reg, mask_next;
   logic [31:0] prdata_reg, prdata_next;

   logic [SYNC_W-1:0] meta_reg, meta_next;
   logic [SYNC_W-1:0] sync_reg, sync_next;
   logic [7:0] pin_prev_reg, pin_prev_next;

   logic [8:0] div_count_reg, div_count_next;
   logic tick_reg, tick_next;
   logic cs_out_reg, cs_out_next;
   logic iow_out_reg, iow_out_next;
   logic [7:0] request_reg, request_next;
   logic sleep_reg, sleep_next;
   logic standby_reg, standby_next;
   remap_t remap_reg, remap_next;

   logic setup_phase;
   logic access_phase;
   logic [7:0] rd_index;
   logic addr_ok;
   logic hit;
   logic [7:0] rd_byte;
   logic [7:0] wr_byte;
   logic [7:0] pins_now;
   logic [7:0] detect;
   logic [7:0] accepted;
   logic [8:0] ratio;
   remap_mode_t remap_mode;

   // Bus decode; zero wait states, read data captured in the setup cycle
   assign setup_phase = psel && !penable;
   assign access_phase = psel && penable;
   assign rd_index = paddr[9:2];
   assign addr_ok = (paddr[APB_AW-1:10] == '0) && (paddr[1:0] == 2'b00);
   assign wr_byte = pwdata[7:0];
   // Frozen clock enable stretches the access rather than losing it
   assign pready = clk_en;

   always_comb begin
      hit = addr_ok;
      rd_byte = 8'h00;
      unique case (rd_index)
         IDX_PIN_SENSE: rd_byte = sense_reg;
         IDX_PIN_ENABLE: rd_byte = enable_reg;
         IDX_SERIAL_TIMER: rd_byte = st_reg;
         IDX_SYSTEM: rd_byte = system_reg;
         IDX_INT_STATUS: rd_byte = status_reg;
         IDX_INT_MASK: rd_byte = mask_reg;
         default: hit = 1'b0;
      endcase
      if (!addr_ok) begin
         rd_byte = 8'h00;
      end
   end

   assign pslverr = access_phase && !hit;

   // Pin events
   assign pins_now = sync_reg[PIN_COUNT-1:0];
   // Pins are active low: level mode asks while low, edge mode on a fall
   assign detect = (sense_reg & pin_prev_reg & ~pins_now) | (~sense_reg & ~pins_now);
   assign accepted = detect & enable_reg;

   assign ratio = TWO_WIRE_RATIO[{st_reg.two_wire_rate_extend, two_wire_div_sel}];
   assign remap_mode = remap_mode_t'(system_reg[SYS_REMAP_HI_BIT:SYS_REMAP_LO_BIT]);

   // Register group
   always_comb begin
      st_next = st_reg;
      system_next = system_reg;
      sense_next = sense_reg;
      enable_next = enable_reg;
      mask_next = mask_reg;
      prdata_next = prdata_reg;
      // Set wins over a write-one clear in the same cycle
      status_next = status_reg | accepted;
      if (setup_phase && !pwrite) begin
         prdata_next = {24'h00_0000, rd_byte};
      end
      if (access_phase && pwrite && hit) begin
         unique case (rd_index)
            IDX_PIN_SENSE: sense_next = wr_byte;
            IDX_PIN_ENABLE: enable_next = wr_byte;
            IDX_SERIAL_TIMER: st_next = serial_timer_t'(wr_byte);
            IDX_SYSTEM: system_next = wr_byte;
            IDX_INT_STATUS: status_next = (status_reg & ~wr_byte) | accepted;
            IDX_INT_MASK: mask_next = wr_byte;
            default: st_next = st_reg;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= serial_timer_t'(SERIAL_TIMER_RESET);
         system_reg <= SYSTEM_RESET;
         sense_reg <= SENSE_RESET;
         enable_reg <= ENABLE_RESET;
         status_reg <= STATUS_RESET;
         mask_reg <= MASK_RESET;
         prdata_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         st_reg <= st_next;
         system_reg <= system_next;
         sense_reg <= sense_next;
         enable_reg <= enable_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         prdata_reg <= prdata_next;
      end
   end

   // Pin synchronisers; idle level of every pin is high
   always_comb begin
      meta_next = {alt_host_io_write_n, alt_host_chip_select_two_n, host_io_write_n, host_chip_select_two_n,
         irq_pin_n};
      sync_next = meta_reg;
      pin_prev_next = pins_now;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '1;
         sync_reg <= '1;
         pin_prev_reg <= 8'hff;
      end else if (clk_en) begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         pin_prev_reg <= pin_prev_next;
      end
   end

   // Divider and output group
   always_comb begin
      div_count_next = DIV_COUNT_RESET;
      tick_next = 1'b0;
      // Divider clears to zero and stays there while the two-wire registers are off
      if (st_reg.two_wire_register_enable) begin
         // Compare with >= so a smaller ratio mid-count cannot run away
         if (div_count_reg >= ratio - 9'h001) begin
            tick_next = 1'b1;
         end else begin
            div_count_next = div_count_reg + 9'h001;
         end
      end
      if (st_reg.slave_input_switch) begin
         cs_out_next = sync_reg[PIN_COUNT+2];
         iow_out_next = sync_reg[PIN_COUNT+3];
      end else begin
         cs_out_next = sync_reg[PIN_COUNT];
         iow_out_next = sync_reg[PIN_COUNT+1];
      end
      request_next = accepted;
      sleep_next = sleep_request && !system_reg[SYS_STANDBY_BIT];
      standby_next = sleep_request && system_reg[SYS_STANDBY_BIT];
      remap_next.active = remap_mode != REMAP_NONE;
      remap_next.rom_lo = ROM_LO_UPPER;
      remap_next.rom_hi = ROM_HI_SHORT;
      remap_next.ram_lo = LARGE_FLASH ? LARGE_RAM_UPPER : SMALL_RAM_UPPER;
      unique case (remap_mode)
         REMAP_NONE: begin
            remap_next.rom_lo = 16'h0000;
            remap_next.rom_hi = 16'h0000;
            remap_next.ram_lo = 16'h0000;
         end
         REMAP_SHORT: remap_next.rom_hi = ROM_HI_SHORT;
         REMAP_LONG: remap_next.rom_hi = ROM_HI_LONG;
         REMAP_BOTTOM: begin
            remap_next.rom_lo = ROM_LO_BOTTOM;
            remap_next.rom_hi = ROM_HI_BOTTOM;
            remap_next.ram_lo = LARGE_FLASH ? LARGE_RAM_BOTTOM : SMALL_RAM_BOTTOM;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_count_reg <= DIV_COUNT_RESET;
         tick_reg <= 1'b0;
         cs_out_reg <= 1'b1;
         iow_out_reg <= 1'b1;
         request_reg <= 8'h00;
         sleep_reg <= 1'b0;
         standby_reg <= 1'b0;
         remap_reg <= '0;
      end else if (clk_en) begin
         div_count_reg <= div_count_next;
         tick_reg <= tick_next;
         cs_out_reg <= cs_out_next;
         iow_out_reg <= iow_out_next;
         request_reg <= request_next;
         sleep_reg <= sleep_next;
         standby_reg <= standby_next;
         remap_reg <= remap_next;
      end
   end

   assign prdata = prdata_reg;
   assign slave_chip_select_two_n = cs_out_reg;
   assign slave_io_write_n = iow_out_reg;
   assign multiproc_comm_enable = st_reg.multiproc_comm_enable;
   assign two_wire_register_enable = st_reg.two_wire_register_enable;
   assign two_wire_ratio = ratio;
   assign two_wire_bit_tick = tick_reg;
   assign port_a_upper_pins_bus_drive = st_reg.extra_buffer_select;
   assign timer_clk_ext = {st_reg.timer_clk_ext_hi, st_reg.timer_clk_ext_lo};
   assign enter_sleep = sleep_reg;
   assign enter_standby = standby_reg;
   assign remap = remap_reg;
   assign irq_request = request_reg;
   assign irq = |(status_reg & mask_reg);

   // Helper: cycles between bit ticks while the ratio holds still
   logic [8:0] gap_reg;
   logic gap_valid_reg;
   logic [8:0] ratio_prev_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_reg <= 9'h000;
         gap_valid_reg <= 1'b0;
         ratio_prev_reg <= 9'h000;
      end else if (clk_en) begin
         ratio_prev_reg <= ratio;
         gap_reg <= tick_reg ? 9'h001 : gap_reg + 9'h001;
         if (ratio != ratio_prev_reg || !st_reg.two_wire_register_enable) begin
            gap_valid_reg <= 1'b0;
         end else if (tick_reg) begin
            gap_valid_reg <= 1'b1;
         end
      end
   end

   property p_route_switch;
      @(posedge pclk) disable iff (!presetn)
      clk_en |=> slave_chip_select_two_n == $past(st_reg.slave_input_switch ? sync_reg[PIN_COUNT+2]
         : sync_reg[PIN_COUNT]);
   endproperty
   a_route_switch: assert property (p_route_switch) else $error("host port select routed wrong");

   property p_multiproc_write;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && access_phase && pwrite && addr_ok && rd_index == IDX_SERIAL_TIMER)
         |=> multiproc_comm_enable == $past(pwdata[ST_MULTIPROC_BIT]);
   endproperty
   a_multiproc_write: assert property (p_multiproc_write) else $error("multiproc enable not written");

   property p_divider_off;
      @(posedge pclk) disable iff (!presetn)
      (!two_wire_register_enable && clk_en) |=> !two_wire_bit_tick ##1 !two_wire_bit_tick || $past(clk_en) == 0;
   endproperty
   a_divider_off: assert property (p_divider_off) else $error("bit tick while two-wire disabled");

   property p_tick_period;
      @(posedge pclk) disable iff (!presetn)
      (tick_reg && gap_valid_reg && ratio == ratio_prev_reg) |-> gap_reg == ratio;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("bit tick period differs from ratio");

   property p_buffer_select;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && access_phase && pwrite && addr_ok && rd_index == IDX_SERIAL_TIMER)
         |=> port_a_upper_pins_bus_drive == $past(pwdata[ST_BUFFER_SEL_BIT]);
   endproperty
   a_buffer_select: assert property (p_buffer_select) else $error("bus drive select not written");

   property p_sleep_kind;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && sleep_request) |=> (enter_standby == $past(system_reg[SYS_STANDBY_BIT]))
         && (enter_sleep != enter_standby);
   endproperty
   a_sleep_kind: assert property (p_sleep_kind) else $error("wrong low-power mode chosen");

   property p_timer_ext;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && access_phase && pwrite && addr_ok && rd_index == IDX_SERIAL_TIMER)
         |=> timer_clk_ext == $past(pwdata[1:0]);
   endproperty
   a_timer_ext: assert property (p_timer_ext) else $error("timer clock extension not written");

   property p_remap_bottom;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && system_reg[SYS_REMAP_HI_BIT:SYS_REMAP_LO_BIT] == 2'b11) |=> remap.active
         && remap.rom_hi == ROM_HI_BOTTOM && remap.ram_lo == (LARGE_FLASH ? LARGE_RAM_BOTTOM : SMALL_RAM_BOTTOM);
   endproperty
   a_remap_bottom: assert property (p_remap_bottom) else $error("bottom remap window wrong");

   property p_level_sense;
      @(posedge pclk) disable iff (!presetn)
      clk_en |=> (irq_request & ~$past(sense_reg)) == ($past(~sense_reg & enable_reg & ~pins_now));
   endproperty
   a_level_sense: assert property (p_level_sense) else $error("level-sensed request wrong");

   property p_enable_gate;
      @(posedge pclk) disable iff (!presetn)
      clk_en |=> (irq_request & ~$past(enable_reg)) == 8'h00;
   endproperty
   a_enable_gate: assert property (p_enable_gate) else $error("request from disabled pin");

   property p_sense_write;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && access_phase && pwrite && addr_ok && rd_index == IDX_PIN_SENSE)
         |=> sense_reg == $past(pwdata[7:0]);
   endproperty
   a_sense_write: assert property (p_sense_write) else $error("sense register not written");

endmodule

//--- verilog/sys_ctrl_pkg.sv
package sys_ctrl_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PIN_SENSE = 8'hc6;
   localparam logic [7:0] IDX_PIN_ENABLE = 8'hc7;
   localparam logic [7:0] IDX_SERIAL_TIMER = 8'hd0;
   localparam logic [7:0] IDX_SYSTEM = 8'hd1;
   localparam logic [7:0] IDX_INT_STATUS = 8'hd2;
   localparam logic [7:0] IDX_INT_MASK = 8'hd3;

   localparam int unsigned APB_AW = 12;
   localparam int unsigned PIN_COUNT = 8;

   // Values after reset
   localparam logic [7:0] SENSE_RESET = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] SERIAL_TIMER_RESET = 8'h00;
   localparam logic [7:0] SYSTEM_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [8:0] DIV_COUNT_RESET = 9'h000;

   // Field positions in the system register
   localparam int unsigned SYS_STANDBY_BIT = 7;
   localparam int unsigned SYS_REMAP_HI_BIT = 1;
   localparam int unsigned SYS_REMAP_LO_BIT = 0;

   // Field positions in the serial/timer register
   localparam int unsigned ST_BUFFER_SEL_BIT = 7;
   localparam int unsigned ST_SWITCH_BIT = 3;
   localparam int unsigned ST_MULTIPROC_BIT = 2;

   typedef struct packed {
      logic extra_buffer_select;
      logic extra_buffer_reserve;
      logic two_wire_rate_extend;
      logic two_wire_register_enable;
      logic slave_input_switch;
      logic multiproc_comm_enable;
      logic timer_clk_ext_hi;
      logic timer_clk_ext_lo;
   } serial_timer_t;

   typedef enum logic [1:0] {
      REMAP_NONE = 2'b00,
      REMAP_SHORT = 2'b01,
      REMAP_LONG = 2'b10,
      REMAP_BOTTOM = 2'b11
   } remap_mode_t;

   typedef struct packed {
      logic active;
      logic [15:0] rom_lo;
      logic [15:0] rom_hi;
      logic [15:0] ram_lo;
   } remap_t;

   // Remapped windows
   localparam logic [15:0] ROM_LO_UPPER = 16'h0080;
   localparam logic [15:0] ROM_HI_SHORT = 16'h00ff;
   localparam logic [15:0] ROM_HI_LONG = 16'h017f;
   localparam logic [15:0] ROM_LO_BOTTOM = 16'h0000;
   localparam logic [15:0] ROM_HI_BOTTOM = 16'h007f;
   localparam logic [15:0] SMALL_RAM_UPPER = 16'hfc80;
   localparam logic [15:0] SMALL_RAM_BOTTOM = 16'hfc00;
   localparam logic [15:0] LARGE_RAM_UPPER = 16'hf880;
   localparam logic [15:0] LARGE_RAM_BOTTOM = 16'hf800;

   // Two-wire divide ratios indexed by {rate_extend, div_sel}
   localparam logic [15:0][8:0] TWO_WIRE_RATIO = {
      9'h100, 9'h0e0, 9'h0c8, 9'h0a0, 9'h080, 9'h060, 9'h050, 9'h038,
      9'h080, 9'h070, 9'h064, 9'h050, 9'h040, 9'h030, 9'h028, 9'h01c};

endpackage

//--- test/far_side_model.sv
`timescale 1ns/1ps
module far_side_model (
   input wire logic pclk,
   input wire logic [7:0] irq_assert,
   input wire logic primary_assert,
   input wire logic alt_assert,
   input wire logic tick,
   output logic [7:0] irq_pin_n,
   output logic host_cs_n,
   output logic host_wr_n,
   output logic alt_cs_n,
   output logic alt_wr_n,
   output int tick_period
);
   int cnt;
   initial begin
      irq_pin_n = 8'hff;
      {host_cs_n, host_wr_n, alt_cs_n, alt_wr_n} = 4'hf;
      cnt = 0;
      tick_period = 0;
   end
   // Pins are asynchronous to the block; change just after an edge
   always @(posedge pclk) begin
      irq_pin_n <= ~irq_assert;
      host_cs_n <= ~primary_assert;
      host_wr_n <= ~primary_assert;
      alt_cs_n <= ~alt_assert;
      alt_wr_n <= ~alt_assert;
   end
   // Cycles between bit ticks, as a two-wire engine would see them
   always @(posedge pclk) begin
      if (tick) begin
         tick_period <= cnt + 1;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

//--- test/system_serial_timer_control_tb.sv
`timescale 1ns/1ps
module system_serial_timer_control_tb;
   import sys_ctrl_pkg::*;
   logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic pready, pslverr, s_cs_n, s_wr_n, mp_en, tw_en, tick, bus_drive, ent_sleep, ent_standby, irq;
   logic [31:0] prdata;
   logic [2:0] div_sel = 3'h0;
   logic [8:0] ratio;
   logic [1:0] tclk;
   logic sleep_request = 0, prim = 0, alt = 0;
   remap_t remap;
   logic [7:0] irq_assert = 8'h00, irq_pin_n, irq_request;
   logic h_cs_n, h_wr_n, a_cs_n, a_wr_n;
   int tick_period, mismatches = 0, n_checks = 0;
   logic [31:0] seed = 32'h9318_09a9;
   logic [7:0] mdl [logic [7:0]];
   logic [7:0] rw_idx [5] = '{IDX_PIN_SENSE, IDX_PIN_ENABLE, IDX_SERIAL_TIMER, IDX_SYSTEM, IDX_INT_MASK};
   int ratios [16] = '{28, 40, 48, 64, 80, 100, 112, 128, 56, 80, 96, 128, 160, 200, 224, 256};
   logic [31:0] v;
   logic e;
   serial_timer_t st;

   always #50 pclk = ~pclk;

   system_serial_timer_control #(.LARGE_FLASH(1'b0)) system_serial_timer_control_inst (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .host_chip_select_two_n(h_cs_n), .host_io_write_n(h_wr_n),
      .alt_host_chip_select_two_n(a_cs_n), .alt_host_io_write_n(a_wr_n),
      .slave_chip_select_two_n(s_cs_n), .slave_io_write_n(s_wr_n), .multiproc_comm_enable(mp_en),
      .two_wire_register_enable(tw_en), .two_wire_div_sel(div_sel), .two_wire_ratio(ratio),
      .two_wire_bit_tick(tick), .port_a_upper_pins_bus_drive(bus_drive), .timer_clk_ext(tclk),
      .sleep_request(sleep_request), .enter_sleep(ent_sleep), .enter_standby(ent_standby),
      .remap(remap), .irq_pin_n(irq_pin_n), .irq_request(irq_request), .irq(irq));

   far_side_model far_side_model_inst (
      .pclk(pclk), .irq_assert(irq_assert), .primary_assert(prim), .alt_assert(alt), .tick(tick),
      .irq_pin_n(irq_pin_n), .host_cs_n(h_cs_n), .host_wr_n(h_wr_n), .alt_cs_n(a_cs_n), .alt_wr_n(a_wr_n),
      .tick_period(tick_period));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      if (mismatches == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Setup, then access held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [31:0] rd,
                      output logic err);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1, {2'b00, idx, 2'b00}, d, v, e);
      mdl[idx] = (idx == IDX_INT_STATUS) ? mdl[idx] & ~d : d;
   endtask

   task automatic rd_check(input logic [7:0] idx);
      apb(0, {2'b00, idx, 2'b00}, 8'h00, v, e);
      check("register read", v, {24'h00_0000, mdl[idx]});
      check("slave error", e, 1'b0);
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      summarize();
   end

   initial begin
      foreach (rw_idx[i]) mdl[rw_idx[i]] = 8'h00;
      mdl[IDX_INT_STATUS] = 8'h00;
      repeat (4) @(posedge pclk);
      presetn <= 1;
      foreach (rw_idx[i]) rd_check(rw_idx[i]);
      rd_check(IDX_INT_STATUS);
      // Flash variant: remap bits may take any value here
      for (int r = 0; r < 3; r++) begin
         foreach (rw_idx[i]) begin
            seed = lfsr(seed);
            wr(rw_idx[i], seed[7:0]);
            rd_check(rw_idx[i]);
         end
         @(negedge pclk);
         st = serial_timer_t'(mdl[IDX_SERIAL_TIMER]);
         check("multiproc", mp_en, st.multiproc_comm_enable);
         check("two wire enable", tw_en, st.two_wire_register_enable);
         check("bus drive", bus_drive, st.extra_buffer_select);
         check("timer ext", tclk, {st.timer_clk_ext_hi, st.timer_clk_ext_lo});
      end
      apb(0, 12'h3f0, 8'h00, v, e);
      check("unmapped data", v, 32'h0000_0000);
      check("unmapped error", e, 1'b1);
      @(posedge pclk);
      clk_en <= 0;
      @(negedge pclk);
      check("pready", pready, 1'b0);
      @(posedge pclk);
      clk_en <= 1;
      // Routing: only the primary group asserted
      prim <= 1;
      for (int s = 0; s < 2; s++) begin
         wr(IDX_SERIAL_TIMER, s ? 8'h08 : 8'h00);
         repeat (6) @(posedge pclk);
         @(negedge pclk);
         check("slave cs", s_cs_n, s[0]);
         check("slave wr", s_wr_n, s[0]);
      end
      prim <= 0;
      for (int x = 0; x < 16; x++) begin
         wr(IDX_SERIAL_TIMER, {2'b00, x[3], 5'b10000});
         div_sel <= x[2:0];
         @(negedge pclk);
         check("ratio", ratio, ratios[x]);
      end
      wr(IDX_SERIAL_TIMER, 8'h10);
      div_sel <= 3'h0;
      repeat (100) @(posedge pclk);
      check("tick period", tick_period, 28);
      for (int m = 0; m < 4; m++) begin
         wr(IDX_SYSTEM, m[7:0]);
         repeat (2) @(posedge pclk);
         @(negedge pclk);
         check("remap active", remap.active, m != 0);
         check("remap rom lo", remap.rom_lo, m == 0 ? 16'h0000 : m == 3 ? 16'h0000 : 16'h0080);
         check("remap rom hi", remap.rom_hi, m == 0 ? 16'h0000 : m == 1 ? 16'h00ff : m == 2 ? 16'h017f : 16'h007f);
         check("remap ram lo", remap.ram_lo, m == 0 ? 16'h0000 : m == 3 ? 16'hfc00 : 16'hfc80);
      end
      for (int s = 0; s < 2; s++) begin
         wr(IDX_SYSTEM, s ? 8'h80 : 8'h00);
         @(posedge pclk);
         sleep_request <= 1;
         @(posedge pclk);
         sleep_request <= 0;
         @(negedge pclk);
         check("sleep", ent_sleep, !s);
         check("standby", ent_standby, s[0]);
      end
      // Pin 0 level, pin 1 not enabled, pin 2 edge
      wr(IDX_INT_MASK, 8'h00);
      wr(IDX_PIN_SENSE, 8'h04);
      wr(IDX_PIN_ENABLE, 8'h05);
      @(posedge pclk);
      irq_assert <= 8'h07;
      repeat (10) @(posedge pclk);
      @(negedge pclk);
      check("requests", irq_request, 8'h01);
      mdl[IDX_INT_STATUS] = 8'h05;
      rd_check(IDX_INT_STATUS);
      check("irq masked", irq, 1'b0);
      wr(IDX_INT_MASK, 8'h04);
      @(negedge pclk);
      check("irq raised", irq, 1'b1);
      wr(IDX_INT_STATUS, 8'h04);
      @(negedge pclk);
      check("irq cleared", irq, 1'b0);
      rd_check(IDX_INT_STATUS);
      irq_assert <= 8'h00;
      repeat (6) @(posedge pclk);
      wr(IDX_INT_STATUS, 8'h01);
      rd_check(IDX_INT_STATUS);
      summarize();
   end
endmodule
